// >>> src/cpps_pkg.sv
// Purpose: Shared constants and carrier types for the core pointer and power register bank.
// Assumes: Byte-wide registers on an 8-bit address, single clock, synchronous reset.
// Notes: Offsets are register addresses; the auxiliary control offset is a local choice.
`default_nettype none
package cpps_pkg;
    // Register addresses.
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_DPL = 8'h82;
    localparam logic [7:0] ADDR_DPH = 8'h83;
    localparam logic [7:0] ADDR_RELOAD = 8'h86;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_AUX1 = 8'hA2;
    // Reset values.
    localparam logic [7:0] RST_PORT0 = 8'hFF;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_DP = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [7:0] RST_AUX1 = 8'h00;
    // Power control and auxiliary control field positions.
    localparam int PC_BAUD = 7;
    localparam int PC_FEAS = 6;
    localparam int PC_RSVD = 5;
    localparam int PC_POF = 4;
    localparam int PC_GF1 = 3;
    localparam int PC_GF0 = 2;
    localparam int PC_PD = 1;
    localparam int PC_IDL = 0;
    localparam int AUX_DPS = 0;
    // Register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cpps_req_t;
    // Low-power state of the core.
    typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_DOWN} cpps_pm_t;
endpackage
`default_nettype wire

// >>> src/cpps_regs.sv
// Purpose: Core pointer, stack and power control register bank.
// Assumes: One 200 MHz clock; rst_n is synchronous; por_n marks a power-on reset.
// Notes: Read data appear in the cycle after the read strobe and only there.
`timescale 1ns/1ps
`default_nettype none
module cpps_regs
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire cpps_pkg::cpps_req_t req,
    input wire logic push_req,
    input wire logic [7:0] push_data,
    input wire logic wake_irq,
    input wire logic [1:0] serial_mode,
    input wire logic t1_baud_src,
    output logic [7:0] rdata,
    output logic [7:0] port_zero_latch,
    output logic [15:0] active_pointer,
    output logic stack_we,
    output logic [7:0] stack_addr,
    output logic [7:0] stack_wdata,
    output logic baud_double_en,
    output logic serial_bit7_is_fe,
    output logic cpu_clk_stop,
    output logic periph_clk_stop
);
    logic [7:0] p0_q;
    logic [7:0] sp_q;
    logic [7:0] dpl_q [2];
    logic [7:0] dph_q [2];
    logic [7:0] reload_q;
    logic [7:0] aux_q;
    logic baud_q, feas_q, pof_q, gf1_q, gf0_q, pd_q, idl_q;
    logic por_q;
    logic pushing_q;
    logic [7:0] push_data_q;
    logic pointer_select;
    logic [7:0] power_control_view;
    cpps_pkg::cpps_pm_t pm_q;

    // Write hit decode used by every process that takes a bus write.
    function automatic logic hit(input cpps_pkg::cpps_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    assign pointer_select = aux_q[cpps_pkg::AUX_DPS];
    // Power control as read back; bit 5 always zero.
    assign power_control_view = {baud_q, feas_q, 1'b0, pof_q, gf1_q, gf0_q, pd_q, idl_q};

    // Port zero latch.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            p0_q <= cpps_pkg::RST_PORT0;
        else if (hit(req, cpps_pkg::ADDR_PORT0))
            p0_q <= req.wdata;
    end

    // Stack pointer increments first; the write follows one cycle later at the new address.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sp_q <= cpps_pkg::RST_SP;
            pushing_q <= 1'b0;
            push_data_q <= 8'h00;
        end
        else
        begin
            pushing_q <= push_req;
            push_data_q <= push_data;
            if (push_req)
                sp_q <= sp_q + 8'h01;
            else if (hit(req, cpps_pkg::ADDR_SP))
                sp_q <= req.wdata;
        end
    end

    // Stack write strobe issued after the increment has landed.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stack_we <= 1'b0;
            stack_addr <= 8'h00;
            stack_wdata <= 8'h00;
        end
        else
        begin
            stack_we <= pushing_q;
            stack_addr <= sp_q;
            stack_wdata <= push_data_q;
        end
    end

    // Two data pointers; the selected one is reached through the pointer byte addresses.
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_dp
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    dpl_q[i] <= cpps_pkg::RST_DP;
                    dph_q[i] <= cpps_pkg::RST_DP;
                end
                else if (pointer_select == 1'(i))
                begin
                    if (hit(req, cpps_pkg::ADDR_DPL))
                        dpl_q[i] <= req.wdata;
                    if (hit(req, cpps_pkg::ADDR_DPH))
                        dph_q[i] <= req.wdata;
                end
            end
        end
    endgenerate

    // Reload byte and auxiliary control.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reload_q <= cpps_pkg::RST_RELOAD;
            aux_q <= cpps_pkg::RST_AUX1;
        end
        else
        begin
            if (hit(req, cpps_pkg::ADDR_RELOAD))
                reload_q <= req.wdata;
            if (hit(req, cpps_pkg::ADDR_AUX1))
                aux_q <= {7'h00, req.wdata[cpps_pkg::AUX_DPS]};
        end
    end

    // Power-on flag: set by power-on reset, untouched by system reset.
    always_ff @(posedge clk)
    begin
        por_q <= !por_n;
        if (por_q)
            pof_q <= 1'b1;
        else if (hit(req, cpps_pkg::ADDR_POWER_CONTROL))
            pof_q <= req.wdata[cpps_pkg::PC_POF];
    end

    // Plain software bits of power control.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            baud_q <= 1'b0;
            feas_q <= 1'b0;
            gf1_q <= 1'b0;
            gf0_q <= 1'b0;
        end
        else if (hit(req, cpps_pkg::ADDR_POWER_CONTROL))
        begin
            baud_q <= req.wdata[cpps_pkg::PC_BAUD];
            feas_q <= req.wdata[cpps_pkg::PC_FEAS];
            gf1_q <= req.wdata[cpps_pkg::PC_GF1];
            gf0_q <= req.wdata[cpps_pkg::PC_GF0];
        end
    end

    // Low-power requests; power-down wins over idle, a wake interrupt clears both.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pd_q <= 1'b0;
            idl_q <= 1'b0;
            pm_q <= cpps_pkg::PM_RUN;
        end
        else
        begin
            case (pm_q)
                cpps_pkg::PM_RUN:
                begin
                    if (hit(req, cpps_pkg::ADDR_POWER_CONTROL))
                    begin
                        pd_q <= req.wdata[cpps_pkg::PC_PD];
                        idl_q <= req.wdata[cpps_pkg::PC_IDL];
                        if (req.wdata[cpps_pkg::PC_PD])
                            pm_q <= cpps_pkg::PM_DOWN;
                        else if (req.wdata[cpps_pkg::PC_IDL])
                            pm_q <= cpps_pkg::PM_IDLE;
                    end
                end
                cpps_pkg::PM_IDLE:
                begin
                    if (wake_irq)
                    begin
                        idl_q <= 1'b0;
                        pm_q <= cpps_pkg::PM_RUN;
                    end
                end
                cpps_pkg::PM_DOWN:
                begin
                    if (wake_irq)
                    begin
                        pd_q <= 1'b0;
                        idl_q <= 1'b0;
                        pm_q <= cpps_pkg::PM_RUN;
                    end
                end
                default:
                    pm_q <= cpps_pkg::PM_RUN;
            endcase
        end
    end

    // Registered outputs toward the core and serial port.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            port_zero_latch <= cpps_pkg::RST_PORT0;
            active_pointer <= 16'h0000;
            baud_double_en <= 1'b0;
            serial_bit7_is_fe <= 1'b0;
            cpu_clk_stop <= 1'b0;
            periph_clk_stop <= 1'b0;
        end
        else
        begin
            port_zero_latch <= p0_q;
            active_pointer <= {dph_q[pointer_select], dpl_q[pointer_select]};
            baud_double_en <= baud_q && ((serial_mode == 2'd2) ||
                ((serial_mode[0]) && t1_baud_src));
            serial_bit7_is_fe <= feas_q;
            cpu_clk_stop <= (pm_q != cpps_pkg::PM_RUN);
            periph_clk_stop <= (pm_q == cpps_pkg::PM_DOWN);
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                cpps_pkg::ADDR_PORT0: rdata <= p0_q;
                cpps_pkg::ADDR_SP: rdata <= sp_q;
                cpps_pkg::ADDR_DPL: rdata <= dpl_q[pointer_select];
                cpps_pkg::ADDR_DPH: rdata <= dph_q[pointer_select];
                cpps_pkg::ADDR_RELOAD: rdata <= reload_q;
                cpps_pkg::ADDR_POWER_CONTROL: rdata <= power_control_view;
                cpps_pkg::ADDR_AUX1: rdata <= aux_q;
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    p0_reset_a: assert property (@(posedge clk) !rst_n |=> p0_q == cpps_pkg::RST_PORT0)
        else $error("Port latch not all ones after reset.");
    p0_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit(req, cpps_pkg::ADDR_PORT0) |=> p0_q == $past(req.wdata))
        else $error("Port latch did not take written value.");
    sp_reset_a: assert property (@(posedge clk) !rst_n |=> sp_q == cpps_pkg::RST_SP)
        else $error("Stack pointer reset value wrong.");
    sequence push_s;
        push_req ##1 1'b1;
    endsequence
    // The push sequence spans the request cycle and the increment cycle; the write follows it.
    sp_push_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_s |=> stack_we && stack_addr == $past(sp_q, 2) + 8'h01)
        else $error("Stack write not at incremented pointer.");
    ptr_join_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> active_pointer == {$past(dph_q[pointer_select]), $past(dpl_q[pointer_select])})
        else $error("Active pointer not formed from pointer bytes.");
    pd_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit(req, cpps_pkg::ADDR_POWER_CONTROL) && pm_q == cpps_pkg::PM_RUN && req.wdata[cpps_pkg::PC_PD]
        |=> pm_q == cpps_pkg::PM_DOWN)
        else $error("Power-down not entered.");
    pd_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        pm_q == cpps_pkg::PM_DOWN && wake_irq |=> !pd_q && !idl_q ##1 !cpu_clk_stop)
        else $error("Wake did not clear power-down.");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(req.rd) && $past(req.addr) == cpps_pkg::ADDR_POWER_CONTROL |-> !rdata[cpps_pkg::PC_RSVD])
        else $error("Reserved bit reads one.");
    pof_set_a: assert property (@(posedge clk) por_q |=> pof_q)
        else $error("Power-on flag not set.");
    fe_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> serial_bit7_is_fe == $past(feas_q))
        else $error("Framing select not forwarded.");
endmodule // cpps_regs
`default_nettype wire

// >>> tb/cpps_tb.sv
// Purpose: Self-checking bench for the core pointer and power register bank.
// Assumes: 200 MHz clock, synchronous active-low reset, read data one cycle after the strobe.
// Notes: A byte model per address predicts every read; unmapped reads must give zero.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, por_n, push_req, wake_irq, t1_baud_src;
    logic [7:0] push_data, rdata, port_zero_latch, stack_addr, stack_wdata, a, d;
    logic [1:0] serial_mode;
    logic [15:0] active_pointer;
    logic stack_we, baud_double_en, serial_bit7_is_fe, cpu_clk_stop, periph_clk_stop;
    cpps_pkg::cpps_req_t req;
    logic [7:0] mdl [logic [7:0]];
    logic [7:0] alist [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h86, 8'h87, 8'h84};
    int errors, total_checks, cyc;

    cpps_regs u_dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .req(req), .push_req(push_req),
        .push_data(push_data), .wake_irq(wake_irq), .serial_mode(serial_mode), .t1_baud_src(t1_baud_src),
        .rdata(rdata), .port_zero_latch(port_zero_latch), .active_pointer(active_pointer),
        .stack_we(stack_we), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
        .baud_double_en(baud_double_en), .serial_bit7_is_fe(serial_bit7_is_fe),
        .cpu_clk_stop(cpu_clk_stop), .periph_clk_stop(periph_clk_stop));

    // Free-running core clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs about 350 cycles.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= wa;
        req.wdata <= wd;
        @(posedge clk);
        req.wr <= 1'b0;
        if (mdl.exists(wa))
            mdl[wa] = (wa == 8'h87) ? (wd & 8'hDF) : wd;
    endtask

    // Reads one byte and compares it with the model; unmapped places read zero.
    task automatic rdc(input logic [7:0] ra);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= ra;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk({8'h00, mdl.exists(ra) ? mdl[ra] : 8'h00}, {8'h00, rdata});
    endtask

    task automatic do_reset(input logic por);
        @(posedge clk);
        rst_n <= 1'b0;
        por_n <= ~por;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        mdl[8'h80] = 8'hFF;
        mdl[8'h81] = 8'h07;
        mdl[8'h82] = 8'h00;
        mdl[8'h83] = 8'h00;
        mdl[8'h86] = 8'h00;
        mdl[8'h87] = por ? 8'h10 : (mdl[8'h87] & 8'h10);
    endtask

    // Pushes one byte; the write must use the already incremented pointer.
    task automatic push(input logic [7:0] pd);
        @(posedge clk);
        push_req <= 1'b1;
        push_data <= pd;
        @(posedge clk);
        push_req <= 1'b0;
        @(posedge clk);
        #1;
        mdl[8'h81] = mdl[8'h81] + 8'h01;
        chk({7'h00, 1'b1, mdl[8'h81]}, {7'h00, stack_we, stack_addr});
        chk({8'h00, pd}, {8'h00, stack_wdata});
    endtask

    task automatic wake();
        @(posedge clk);
        wake_irq <= 1'b1;
        @(posedge clk);
        wake_irq <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        mdl[8'h87] = mdl[8'h87] & 8'hFC;
    endtask

    // Main sequence.
    initial
    begin
        {rst_n, por_n, push_req, wake_irq, t1_baud_src, serial_mode, push_data} = '0;
        req = '0;
        void'($urandom(32'h43f7_fcb0));
        do_reset(1'b1);
        #1;
        chk(16'h00FF, {8'h00, port_zero_latch});
        foreach (alist[i]) rdc(alist[i]);
        push(8'h5A);
        wr(8'h81, 8'h20);
        push(8'hC3);
        rdc(8'h81);
        for (int i = 0; i < 40; i++)
        begin
            a = alist[$urandom % 7];
            d = 8'($urandom);
            if (a == 8'h86 && d == 8'hFF) d = 8'hFE;
            wr(a, (a == 8'h87) ? (d & 8'hFC) : d);
            if (a == 8'h80)
            begin
                repeat (2) @(posedge clk);
                #1;
                chk({8'h00, d}, {8'h00, port_zero_latch});
            end
            rdc(a);
        end
        wr(8'hA2, 8'h00);
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        repeat (2) @(posedge clk);
        #1;
        chk(16'h1234, active_pointer);
        wr(8'hA2, 8'h01);
        wr(8'h82, 8'hCD);
        wr(8'h83, 8'hAB);
        repeat (2) @(posedge clk);
        #1;
        chk(16'hABCD, active_pointer);
        wr(8'hA2, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk(16'h1234, active_pointer);
        mdl[8'h82] = 8'h34;
        mdl[8'h83] = 8'h12;
        rdc(8'h82);
        for (int s = 0; s < 2; s++)
        begin
            wr(8'h87, s[0] ? 8'hC0 : 8'h00);
            for (int m = 0; m < 8; m++)
            begin
                serial_mode <= m[1:0];
                t1_baud_src <= m[2];
                repeat (3) @(posedge clk);
                #1;
                chk({15'h0, s[0] & (m[1:0] == 2'd2 | (m[0] & m[2]))}, {15'h0, baud_double_en});
                chk({15'h0, s[0]}, {15'h0, serial_bit7_is_fe});
            end
        end
        wr(8'h87, 8'h03);
        repeat (2) @(posedge clk);
        #1;
        chk(16'h0003, {14'h0, cpu_clk_stop, periph_clk_stop});
        wake();
        chk(16'h0000, {14'h0, cpu_clk_stop, periph_clk_stop});
        rdc(8'h87);
        wr(8'h87, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk(16'h0002, {14'h0, cpu_clk_stop, periph_clk_stop});
        wake();
        chk(16'h0000, {14'h0, cpu_clk_stop, periph_clk_stop});
        // A set flag must survive a system reset, and a clear one must not be set by it.
        wr(8'h87, 8'h10);
        do_reset(1'b0);
        rdc(8'h87);
        rdc(8'h80);
        wr(8'h87, 8'h00);
        do_reset(1'b0);
        rdc(8'h87);
        do_reset(1'b1);
        rdc(8'h87);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
